// ### pkg/dci_pkg.sv
// package: constants, register map and event carrier for the dma channel interrupt control block
package dci_pkg;
  // ==========================================================
  // channel count
  localparam int NCH = 8;
  localparam int NCH_RED = 4;
  // ==========================================================
  // register map (byte addresses on the apb bus)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SSA_OFS = 12'h010;
  localparam int CH_SHIFT = 5;
  localparam logic [11:0] ISTAT_OFS = 12'h100;
  localparam logic [11:0] ICLR_OFS = 12'h104;
  localparam logic [11:0] IEN_OFS = 12'h108;
  // ==========================================================
  // alias operations, selected by address bits 3:2
  localparam logic [1:0] OP_WR = 2'h0;
  localparam logic [1:0] OP_CLR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INV = 2'h3;
  // ==========================================================
  // control register layout and reset values
  localparam logic [31:0] CTRL_MASK = 32'h00ff00ff;
  localparam int IE_LSB = 16;
  localparam int FLAG_LSB = 0;
  localparam int F_SRC_DONE = 7;
  localparam int F_SRC_HALF = 6;
  localparam int F_DST_DONE = 5;
  localparam int F_DST_HALF = 4;
  localparam int F_BLOCK = 3;
  localparam int F_CELL = 2;
  localparam int F_ABORT = 1;
  localparam int F_ADDR_ERR = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [NCH-1:0] CMP_RST = 8'hff;
  // ==========================================================
  // per-channel event inputs from the transfer engine
  typedef struct packed {
    logic [15:0] src_pointer;
    logic [15:0] src_size;
    logic dst_done;
    logic dst_half;
    logic block_done;
    logic cell_done;
    logic abort;
    logic addr_err;
  } dci_chan_ev_t;
endpackage

// ### design/dci_top.sv
// module: dma channel interrupt control and source start address registers behind apb
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module dci_top import dci_pkg::*; #(
  parameter bit REDUCED = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transfer engine events
  input wire dci_chan_ev_t [NCH-1:0] chan_ev,
  // interrupt requests
  output logic [NCH-1:0] chan_irq,
  output logic irq
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wd, input logic [1:0] op);
    logic [31:0] r;
    r = old;
    unique case (op)
      OP_WR: r = wd;
      OP_CLR: r = old & ~wd;
      OP_SET: r = old | wd;
      OP_INV: r = old ^ wd;
    endcase
    return r;
  endfunction

  function automatic logic chan_exists(input int c);
    return !(REDUCED && c >= NCH_RED);
  endfunction

  // ==========================================================
  // state
  logic [7:0] ie [NCH];
  logic [7:0] flag [NCH];
  logic [31:0] ssa [NCH];
  logic [NCH-1:0] eq_q;
  logic [NCH-1:0] half_q;
  logic [7:0] stat;
  logic [7:0] ien;
  logic [7:0] next_ie [NCH];
  logic [7:0] next_flag [NCH];
  logic [31:0] next_ssa [NCH];
  logic [NCH-1:0] next_eq;
  logic [NCH-1:0] next_half;
  logic [NCH-1:0] next_chan_irq;
  logic [7:0] next_stat;
  logic [7:0] next_ien;
  logic next_irq;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // ==========================================================
  // address decode
  logic acc;
  logic wr_en;
  logic [2:0] a_ch;
  logic [1:0] a_op;
  logic a_ssa;
  logic a_chan;
  logic ch_ok;

  always_comb begin
    acc = psel & penable;
    wr_en = acc & pready & pwrite;
    a_ch = paddr[7:5];
    a_op = paddr[3:2];
    a_ssa = paddr[4];
    a_chan = (paddr[11:8] == 4'h0);
    ch_ok = a_chan && !(REDUCED && int'(a_ch) >= NCH_RED);
  end

  // ==========================================================
  // channel registers and event flags
  always_comb begin
    logic [31:0] tmp;
    logic [7:0] hw;
    tmp = RST_WORD;
    hw = RST_BYTE;
    for (int c = 0; c < NCH; c++) begin
      next_ie[c] = ie[c];
      next_flag[c] = flag[c];
      next_ssa[c] = ssa[c];
      next_eq[c] = (chan_ev[c].src_pointer == chan_ev[c].src_size);
      next_half[c] = (chan_ev[c].src_pointer == {1'b0, chan_ev[c].src_size[15:1]});
      if (wr_en && ch_ok && a_ch == 3'(c)) begin
        if (a_ssa) begin
          next_ssa[c] = apply_op(ssa[c], pwdata, a_op);
        end else begin
          tmp = apply_op({8'h00, ie[c], 8'h00, flag[c]}, pwdata & CTRL_MASK, a_op);
          next_ie[c] = tmp[IE_LSB +: 8];
          next_flag[c] = tmp[FLAG_LSB +: 8];
        end
      end
      hw = RST_BYTE;
      hw[F_SRC_DONE] = next_eq[c] & ~eq_q[c];
      hw[F_SRC_HALF] = next_half[c] & ~half_q[c];
      hw[F_DST_DONE] = chan_ev[c].dst_done;
      hw[F_DST_HALF] = chan_ev[c].dst_half;
      hw[F_BLOCK] = chan_ev[c].block_done;
      hw[F_CELL] = chan_ev[c].cell_done;
      hw[F_ABORT] = chan_ev[c].abort;
      hw[F_ADDR_ERR] = chan_ev[c].addr_err;
      next_flag[c] = next_flag[c] | hw;
      if (!chan_exists(c)) begin
        next_ie[c] = RST_BYTE;
        next_flag[c] = RST_BYTE;
        next_ssa[c] = RST_WORD;
      end
      next_chan_irq[c] = |(next_flag[c] & next_ie[c]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        ie[c] <= RST_BYTE;
        flag[c] <= RST_BYTE;
        ssa[c] <= RST_WORD;
      end
      eq_q <= CMP_RST;
      half_q <= CMP_RST;
      chan_irq <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        ie[c] <= next_ie[c];
        flag[c] <= next_flag[c];
        ssa[c] <= next_ssa[c];
      end
      eq_q <= next_eq;
      half_q <= next_half;
      chan_irq <= next_chan_irq;
    end
  end

  // ==========================================================
  // block interrupt status, clear and enable
  always_comb begin
    next_stat = stat;
    next_ien = ien;
    if (wr_en && paddr == ICLR_OFS) begin
      next_stat = stat & ~pwdata[7:0];
    end
    if (wr_en && paddr == IEN_OFS) begin
      next_ien = pwdata[7:0];
    end
    next_stat = next_stat | (next_chan_irq & ~chan_irq);
    next_irq = |(next_stat & next_ien);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= RST_BYTE;
      ien <= RST_BYTE;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      ien <= next_ien;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // apb answer: one wait state, data and error registered
  always_comb begin
    next_pready = acc & ~pready;
    next_prdata = RST_WORD;
    next_pslverr = 1'b0;
    if (acc && !pready) begin
      if (ch_ok) begin
        if (a_op == OP_WR) begin
          next_prdata = a_ssa ? ssa[a_ch] : ({8'h00, ie[a_ch], 8'h00, flag[a_ch]} & CTRL_MASK);
        end
      end else if (paddr == ISTAT_OFS) begin
        next_prdata = {24'h000000, stat};
      end else if (paddr == IEN_OFS) begin
        next_prdata = {24'h000000, ien};
      end else if (paddr != ICLR_OFS) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // checks
  logic [NCH*8-1:0] flags_v;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      flags_v[c*8 +: 8] = flag[c];
    end
  end

  flags_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wr_en) |-> ((flags_v & $past(flags_v)) == $past(flags_v)))
    else $error("flag dropped without a software write");

  src_done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chan_ev[0].src_pointer == chan_ev[0].src_size) && !eq_q[0] |=> flag[0][F_SRC_DONE])
    else $error("source done flag not set on pointer match");

  src_half_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (chan_ev[0].src_pointer == {1'b0, chan_ev[0].src_size[15:1]}) && !half_q[0] |=> flag[0][F_SRC_HALF])
    else $error("source half flag not set on midpoint");

  chan_request_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 chan_irq[1] == |(flag[1] & ie[1]))
    else $error("channel request disagrees with flags and enables");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pready && ch_ok && !a_ssa |=> (prdata & ~CTRL_MASK) == 32'h00000000)
    else $error("reserved control bits read nonzero");

  reduced_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    REDUCED |-> (flags_v[NCH*8-1:NCH_RED*8] == '0) && (ssa[NCH-1] == RST_WORD))
    else $error("absent channel holds state");

  set_alias_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && ch_ok && a_ch == 3'h0 && !a_ssa && a_op == OP_SET
      |=> (ie[0] & $past(pwdata[IE_LSB +: 8])) == $past(pwdata[IE_LSB +: 8]))
    else $error("set alias did not set enables");

  clr_alias_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && ch_ok && a_ch == 3'h2 && !a_ssa && a_op == OP_CLR |=> (ie[2] & $past(pwdata[IE_LSB +: 8])) == 8'h00)
    else $error("clear alias did not clear enables");

  enable_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ie[3] == RST_BYTE && flag[3] == RST_BYTE)
    else $error("enables or flags not zero after reset");

  irq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(stat & ien))
    else $error("block interrupt disagrees with status");

  ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    chan_ev[1].addr_err && wr_en && ch_ok && a_ch == 3'h1 && !a_ssa |=> flag[1][F_ADDR_ERR])
    else $error("event lost against a software write");

  event_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    chan_ev[2].block_done |=> flag[2][F_BLOCK])
    else $error("block event did not set its flag");

  enables_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(ie[0]))
    else $error("enables changed without a software write");

  alias_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pready && ch_ok && a_op != OP_WR |=> prdata == RST_WORD)
    else $error("alias address returned data");

  inv_alias_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && ch_ok && a_ch == 3'h3 && !a_ssa && a_op == OP_INV
      |=> ie[3] == ($past(ie[3]) ^ $past(pwdata[IE_LSB +: 8])))
    else $error("invert alias did not toggle enables");

  absent_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pready && a_chan && !ch_ok |=> pready && pslverr)
    else $error("absent channel access not refused");

  reset_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> flags_v == '0 && chan_irq == '0 && !irq && !pready)
    else $error("outputs or flags not quiet after reset");

  status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wr_en) |-> (stat & $past(stat)) == $past(stat))
    else $error("status bit dropped without a software write");

endmodule // dci_top

// ### tb/tb_top.sv
// testbench: apb registers, aliases, events and interrupt requests
`timescale 1ns/1ns
module tb_top import dci_pkg::*;;
  // ==========================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dci_chan_ev_t [NCH-1:0] chan_ev = '0;
  logic [NCH-1:0] chan_irq;
  logic irq;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [NCH-1:0] chan_irq_r;
  logic [31:0] rd_r;
  logic er_r;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int ch;
  logic [31:0] rd;
  logic er;
  logic [31:0] v;
  logic [15:0] sz;
  logic [31:0] model [NCH];
  always #50 pclk = ~pclk;
  dci_top #(.REDUCED(1'b0)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_ev(chan_ev), .chan_irq(chan_irq), .irq(irq));
  // reduced variant on the same bus and events, answers in step with dut
  dci_top #(.REDUCED(1'b1)) dut_red (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_r), .pready(),
    .pslverr(pslverr_r), .chan_ev(chan_ev), .chan_irq(chan_irq_r), .irq());
  // ==========================================================
  // helpers
  task automatic summarize();
    $display("counts: checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    rd_r = prdata_r;
    er_r = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] cbase(input int c);
    return 12'(c << CH_SHIFT);
  endfunction
  function automatic logic [31:0] alias_res(input logic [31:0] o, input logic [1:0] op, input logic [31:0] d);
    case (op)
      OP_CLR: return o & ~d & CTRL_MASK;
      OP_SET: return (o | d) & CTRL_MASK;
      OP_INV: return (o ^ d) & CTRL_MASK;
      default: return d & CTRL_MASK;
    endcase
  endfunction
  // ==========================================================
  // tests
  initial begin
    v = $urandom(32'h8d352a3f);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      model[c] = RST_WORD;
      apb(1'b0, cbase(c), 32'h0);
      chk("ctrl reset", RST_WORD, rd);
      apb(1'b0, cbase(c) + SSA_OFS, 32'h0);
      chk("ssa reset", RST_WORD, rd);
    end
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      ch = (i < NCH) ? i : $urandom_range(NCH - 1);
      v = (i < 4) ? 32'hffffffff : $urandom;
      apb(1'b1, cbase(ch) + 12'(i % 4 * 4), v);
      model[ch] = alias_res(model[ch], 2'(i % 4), v);
      apb(1'b0, cbase(ch) + 12'(i % 4 * 4), 32'h0);
      chk("alias read", (i % 4 == 0) ? model[ch] : 32'h0, rd);
      apb(1'b0, cbase(ch), 32'h0);
      chk("ctrl", model[ch], rd);
      chk("chan irq", {31'h0, |(model[ch][23:16] & model[ch][7:0])}, {31'h0, chan_irq[ch]});
      chk("reduced err", {31'h0, ch >= NCH_RED}, {31'h0, er_r});
      chk("reduced ctrl", (ch < NCH_RED) ? model[ch] : 32'h0, rd_r);
      chk("reduced irq", {31'h0, (ch < NCH_RED) && |(model[ch][23:16] & model[ch][7:0])}, {31'h0, chan_irq_r[ch]});
      apb(1'b1, cbase(ch) + SSA_OFS, v);
      apb(1'b0, cbase(ch) + SSA_OFS, 32'h0);
      chk("ssa", v, rd);
      chk("reduced ssa", (ch < NCH_RED) ? v : 32'h0, rd_r);
    end
    $display("test alias done");
    for (int c = 0; c < NCH; c++) begin
      for (int b = 0; b < 6; b++) begin
        apb(1'b1, cbase(c), 32'h0);
        chan_ev[c][b] <= 1'b1;
        @(posedge pclk);
        chan_ev[c][b] <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, cbase(c), 32'h0);
        chk("event flag", 32'h1 << b, rd);
        chk("reduced flag", (c < NCH_RED) ? 32'h1 << b : 32'h0, rd_r);
        chk("irq off", 32'h0, {31'h0, chan_irq[c]});
        apb(1'b1, cbase(c) + 12'h008, 32'h1 << (b + IE_LSB));
        repeat (2) @(posedge pclk);
        chk("irq on", 32'h1, {31'h0, chan_irq[c]});
        if (b == 0) begin
          apb(1'b0, ISTAT_OFS, 32'h0);
          chk("status", 32'h1 << c, rd & (32'h1 << c));
          apb(1'b1, IEN_OFS, 32'h1 << c);
          repeat (2) @(posedge pclk);
          chk("block irq", 32'h1, {31'h0, irq});
          apb(1'b1, ICLR_OFS, 32'h1 << c);
          repeat (2) @(posedge pclk);
          chk("block irq clear", 32'h0, {31'h0, irq});
          apb(1'b1, IEN_OFS, 32'h0);
          chan_ev[c][b] <= 1'b1;
          apb(1'b1, cbase(c) + 12'h004, 32'h1 << b);
          chan_ev[c][b] <= 1'b0;
          apb(1'b0, cbase(c), 32'h0);
          chk("set wins", (32'h1 << (b + IE_LSB)) | (32'h1 << b), rd);
        end
        apb(1'b1, cbase(c) + 12'h004, 32'h1 << b);
        repeat (2) @(posedge pclk);
        chk("flag cleared", 32'h0, {31'h0, chan_irq[c]});
      end
      apb(1'b1, cbase(c), 32'h0);
      sz = 16'($urandom_range(65535, 4));
      chan_ev[c].src_size <= sz;
      @(posedge pclk);
      chan_ev[c].src_pointer <= sz >> 1;
      apb(1'b0, cbase(c), 32'h0);
      chk("half flag", 32'h40, rd);
      chan_ev[c].src_pointer <= sz;
      apb(1'b0, cbase(c), 32'h0);
      chk("done flag", 32'hc0, rd);
    end
    $display("test events done");
    apb(1'b0, 12'h10c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, ICLR_OFS, 32'h0);
    chk("clear reg read", 32'h0, rd);
    $display("test map done");
    summarize();
  end
endmodule // tb_top
